// ### rtl/dpsfa_pkg.sv
package dpsfa_pkg;

    typedef enum logic [1:0] {
        MODE_AUTO,
        MODE_FORCE_LOCKED,
        MODE_FORCE_FREERUN,
        MODE_FORCE_HOLDOVER
    } dpsfa_mode_t;

    typedef enum logic [2:0] {
        ST_FREERUN,
        ST_LOCK_ACQUIRE,
        ST_LOCKED,
        ST_HOLDOVER,
        ST_LOCK_RECOVER
    } dpsfa_state_t;

    // frame input rate codes, informational for software
    typedef enum logic [3:0] {
        RATE_EPPS,
        RATE_1PPS,
        RATE_5PPS,
        RATE_10PPS,
        RATE_50HZ,
        RATE_100HZ,
        RATE_1KHZ,
        RATE_2KHZ,
        RATE_4KHZ,
        RATE_8KHZ
    } dpsfa_rate_t;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_LOCKCFG = 8'h04;
    localparam logic [7:0] OFS_OUTDIV  = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_SEL     = 8'h10;

    // CTRL field positions
    localparam int CTRL_MODE_LSB     = 0;
    localparam int CTRL_FRAME_EN     = 2;
    localparam int CTRL_SYNC_EN      = 3;
    localparam int CTRL_FALL_EDGE    = 4;
    localparam int CTRL_PW_LSB       = 5;
    localparam int CTRL_IN_RATE_LSB  = 8;
    localparam int CTRL_OUT_FRAME    = 12;
    localparam int CTRL_REVERTIVE    = 13;
    localparam int CTRL_SYSTEM_CH    = 14;

    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] LOCKCFG_RST = 32'h0064_0010;
    localparam logic [31:0] OUTDIV_RST  = 32'h0000_0004;
    localparam logic [31:0] SEL_RST     = 32'h0000_0000;

    localparam int CLK_MHZ        = 100;
    localparam int MIN_PULSE_NS   = 10;
    localparam int MIN_PULSE_CYC  = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dpsfa_apb_rsp_t;

endpackage : dpsfa_pkg

// ### rtl/dpsfa_channel.sv
`timescale 1ns/10ps
`default_nettype none
module dpsfa_channel #(
    parameter int NREF  = 4,
    parameter int NOUT  = 4,
    parameter int FW    = 16,
    parameter int PEW   = 16
) (
    input  wire logic            CLK_I,            // system clock, 100 MHz
    input  wire logic            RST_N_I,          // synchronous reset, active low
    input  wire logic            PSEL_I,           // apb select
    input  wire logic            PENABLE_I,        // apb enable
    input  wire logic            PWRITE_I,         // apb direction
    input  wire logic [7:0]      PADDR_I,          // apb byte address
    input  wire logic [31:0]     PWDATA_I,         // apb write data
    output logic      [31:0]     PRDATA_O,         // apb read data
    output logic                 PREADY_O,         // apb ready
    output logic                 PSLVERR_O,        // apb error, unmapped address
    input  wire logic [NREF-1:0] REF_PIN_I,        // reference input pins, async
    input  wire logic [NREF-1:0] REF_QUAL_I,       // qualified per reference
    input  wire logic [NREF-1:0] REF_PRIO_HI_I,    // higher priority than selected
    input  wire logic [PEW-1:0]  PHASE_ERR_I,      // loop phase error magnitude
    input  wire logic [FW-1:0]   LOOP_FREQ_I,      // loop frequency word
    input  wire logic [FW-1:0]   COMBO_FREQ_I,     // combo master frequency
    input  wire logic            COMBO_EN_I,       // combo slave mode
    output logic      [FW-1:0]   FREQ_CTRL_O,      // frequency steering word
    output logic                 USE_REF_O,        // loop follows reference
    output logic      [2:0]      STATE_O,          // operating state
    output logic      [NREF-1:0] REF_SEL_O,        // one-hot selected reference
    output logic                 ALIGN_O,          // alignment strobe to dividers
    output logic      [NOUT-1:0] OUT_CLK_O,        // aligned output clocks
    output logic      [NOUT-1:0] OUT_FRAME_O       // frame or sync outputs
);

    typedef struct packed {
        logic [31:0]          ctrl;
        logic [31:0]          lockcfg;
        logic [31:0]          outdiv;
        logic [31:0]          sel;
        dpsfa_pkg::dpsfa_apb_rsp_t rsp;
        logic [NREF-1:0]      s1, s2, s3;
        logic [NREF-1:0]      refsel;
        dpsfa_pkg::dpsfa_state_t st;
        logic [15:0]          lockcnt;
        logic [FW-1:0]        hold_freq;
        logic [FW-1:0]        freq;
        logic                 use_ref;
        logic                 armed;
        logic                 align;
        logic [15:0]          divcnt;
        logic [15:0]          pwcnt;
        logic [NOUT-1:0]      oclk;
        logic [NOUT-1:0]      ofrm;
    } dpsfa_st_t;

    dpsfa_st_t q, d;

    dpsfa_pkg::dpsfa_mode_t mode;
    logic [3:0]  fin_idx, clk_idx, fout_mask;
    logic        ref_clk, frame_prev, clk_prev;
    logic        frame_edge, clk_rise, sync_edge;
    logic        sel_disq, any_qual, locked_now, hi_avail, forced_sel;
    logic [NREF-1:0] best;
    logic [15:0] pw_cycles;

    always_comb begin
        mode      = dpsfa_pkg::dpsfa_mode_t'(q.ctrl[dpsfa_pkg::CTRL_MODE_LSB +: 2]);
        fin_idx   = q.sel[3:0];
        clk_idx   = q.sel[7:4];
        fout_mask = q.sel[11:8];
        frame_prev = q.s3[fin_idx[1:0]];
        ref_clk   = q.s2[clk_idx[1:0]];
        clk_prev  = q.s3[clk_idx[1:0]];
        frame_edge = q.ctrl[dpsfa_pkg::CTRL_FALL_EDGE]
                   ? (frame_prev && !q.s2[fin_idx[1:0]])
                   : (!frame_prev && q.s2[fin_idx[1:0]]);
        clk_rise  = !clk_prev && ref_clk;
        sync_edge = q.ctrl[dpsfa_pkg::CTRL_SYNC_EN] && frame_edge;
        sel_disq  = |(q.refsel & ~REF_QUAL_I);
        any_qual  = |REF_QUAL_I;
        locked_now = (q.lockcnt >= q.lockcfg[31:16]);
        best = '0;
        for (int i = NREF - 1; i >= 0; i--) begin
            if (REF_QUAL_I[i] && REF_PRIO_HI_I[i]) begin
                best = '0;
                best[i] = 1'b1;
            end
        end
        if (best == '0) begin
            for (int i = NREF - 1; i >= 0; i--) begin
                if (REF_QUAL_I[i]) begin
                    best = '0;
                    best[i] = 1'b1;
                end
            end
        end
        hi_avail   = q.ctrl[dpsfa_pkg::CTRL_REVERTIVE] && |(REF_QUAL_I & REF_PRIO_HI_I);
        forced_sel = q.sel[16] && (q.refsel != (NREF'(1) << q.sel[13:12]));
        // widen first so the widest code does not wrap to zero
        pw_cycles  = 16'({1'b0, q.ctrl[dpsfa_pkg::CTRL_PW_LSB +: 3]} + 4'd1) << 2;
    end

    always_comb begin
        d = q;
        d.rsp.pready  = 1'b0;
        d.rsp.pslverr = 1'b0;
        d.s1 = REF_PIN_I;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // writes land only on the edge that completes the access
        if (PSEL_I && PENABLE_I && q.rsp.pready && PWRITE_I) begin
            if (PADDR_I == dpsfa_pkg::OFS_CTRL) begin
                d.ctrl = PWDATA_I;
            end else if (PADDR_I == dpsfa_pkg::OFS_LOCKCFG) begin
                d.lockcfg = PWDATA_I;
            end else if (PADDR_I == dpsfa_pkg::OFS_OUTDIV) begin
                d.outdiv = PWDATA_I;
            end else if (PADDR_I == dpsfa_pkg::OFS_SEL) begin
                d.sel = PWDATA_I;
            end
        end
        if (PSEL_I && PENABLE_I && !q.rsp.pready) begin
            d.rsp.pready = 1'b1;
            d.rsp.prdata = '0;
            if (PADDR_I == dpsfa_pkg::OFS_CTRL) begin
                d.rsp.prdata = q.ctrl;
            end else if (PADDR_I == dpsfa_pkg::OFS_LOCKCFG) begin
                d.rsp.prdata = q.lockcfg;
            end else if (PADDR_I == dpsfa_pkg::OFS_OUTDIV) begin
                d.rsp.prdata = q.outdiv;
            end else if (PADDR_I == dpsfa_pkg::OFS_SEL) begin
                d.rsp.prdata = q.sel;
            end else if (PADDR_I == dpsfa_pkg::OFS_STATUS) begin
                d.rsp.prdata = {20'h0_0000, q.refsel[3:0] & 4'hF, 1'b0,
                                q.use_ref, locked_now, 1'b0, 1'b0, q.st};
            end else begin
                d.rsp.pslverr = 1'b1;
            end
        end

        // lock qualifier: phase error at or under threshold for programmed cycles
        if (PHASE_ERR_I <= q.lockcfg[PEW-1:0] && q.refsel != '0) begin
            if (!locked_now) d.lockcnt = q.lockcnt + 16'h0001;
        end else begin
            d.lockcnt = '0;
        end

        // reference switching
        if (sel_disq || hi_avail || forced_sel || q.refsel == '0) begin
            d.refsel = q.sel[16] ? (NREF'(1) << q.sel[13:12]) & REF_QUAL_I : best;
            d.lockcnt = '0;
        end

        case (mode)
            dpsfa_pkg::MODE_FORCE_LOCKED:   d.st = dpsfa_pkg::ST_LOCKED;
            dpsfa_pkg::MODE_FORCE_FREERUN:  d.st = dpsfa_pkg::ST_FREERUN;
            dpsfa_pkg::MODE_FORCE_HOLDOVER: d.st = dpsfa_pkg::ST_HOLDOVER;
            default: begin
                case (q.st)
                    dpsfa_pkg::ST_FREERUN:
                        if (any_qual && q.refsel != '0) d.st = dpsfa_pkg::ST_LOCK_ACQUIRE;
                    dpsfa_pkg::ST_LOCK_ACQUIRE:
                        if (!any_qual) d.st = dpsfa_pkg::ST_FREERUN;
                        else if (locked_now) d.st = dpsfa_pkg::ST_LOCKED;
                    dpsfa_pkg::ST_LOCKED:
                        if (!any_qual) d.st = dpsfa_pkg::ST_HOLDOVER;
                        else if (sel_disq || hi_avail || forced_sel)
                            d.st = dpsfa_pkg::ST_LOCK_RECOVER;
                    dpsfa_pkg::ST_HOLDOVER:
                        if (any_qual) d.st = dpsfa_pkg::ST_LOCK_RECOVER;
                    dpsfa_pkg::ST_LOCK_RECOVER:
                        if (!any_qual) d.st = dpsfa_pkg::ST_HOLDOVER;
                        else if (locked_now && !(sel_disq || hi_avail || forced_sel))
                            d.st = dpsfa_pkg::ST_LOCKED;
                    default: d.st = dpsfa_pkg::ST_FREERUN;
                endcase
            end
        endcase

        // frequency steering per state
        case (q.st)
            dpsfa_pkg::ST_FREERUN: begin
                d.use_ref = 1'b0;
                d.freq    = COMBO_EN_I ? COMBO_FREQ_I : '0;
            end
            dpsfa_pkg::ST_HOLDOVER: begin
                d.use_ref = 1'b0;
                d.freq    = q.hold_freq;
            end
            dpsfa_pkg::ST_LOCKED: begin
                d.use_ref   = 1'b1;
                d.freq      = LOOP_FREQ_I;
                d.hold_freq = LOOP_FREQ_I;
            end
            default: begin
                d.use_ref = 1'b1;
                d.freq    = LOOP_FREQ_I;
            end
        endcase

        // frame mode: edge arms, next ref rising edge aligns
        d.align = 1'b0;
        if (q.ctrl[dpsfa_pkg::CTRL_FRAME_EN] && !q.ctrl[dpsfa_pkg::CTRL_SYNC_EN]) begin
            if (frame_edge) d.armed = 1'b1;
            else if (q.armed && clk_rise) begin
                d.armed = 1'b0;
                d.align = 1'b1;
            end
        end else begin
            d.armed = 1'b0;
            if (sync_edge) d.align = 1'b1;
        end

        // output clock and frame generation, both restart on alignment
        if (q.align) begin
            d.divcnt = '0;
            d.oclk   = '1;
            d.pwcnt  = pw_cycles;
        end else begin
            if (q.divcnt + 16'h0001 >= q.outdiv[15:0]) begin
                d.divcnt = '0;
                d.oclk   = ~q.oclk;
            end else begin
                d.divcnt = q.divcnt + 16'h0001;
            end
            if (q.pwcnt != '0) d.pwcnt = q.pwcnt - 16'h0001;
        end
        d.ofrm = {NOUT{q.pwcnt != '0}} & NOUT'(fout_mask);

        // system channel keeps outputs quiet
        if (q.ctrl[dpsfa_pkg::CTRL_SYSTEM_CH]) begin
            d.oclk = '0;
            d.ofrm = '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            q           <= '0;
            q.ctrl      <= dpsfa_pkg::CTRL_RST;
            q.lockcfg   <= dpsfa_pkg::LOCKCFG_RST;
            q.outdiv    <= dpsfa_pkg::OUTDIV_RST;
            q.sel       <= dpsfa_pkg::SEL_RST;
            q.st        <= dpsfa_pkg::ST_FREERUN;
        end else begin
            q <= d;
        end
    end

    assign PRDATA_O    = q.rsp.prdata;
    assign PREADY_O    = q.rsp.pready;
    assign PSLVERR_O   = q.rsp.pslverr;
    assign FREQ_CTRL_O = q.freq;
    assign USE_REF_O   = q.use_ref;
    assign STATE_O     = q.st;
    assign REF_SEL_O   = q.refsel;
    assign ALIGN_O     = q.align;
    assign OUT_CLK_O   = q.oclk;
    assign OUT_FRAME_O = q.ofrm;

endmodule : dpsfa_channel
`default_nettype wire

// ### sim/dpsfa_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module dpsfa_asserts #(
    parameter int FW = 16
) (
    input wire logic          CLK_I,       // clock
    input wire logic          RST_N_I,     // reset
    input wire logic          PSEL_I,      // select
    input wire logic          PENABLE_I,   // enable
    input wire logic          PWRITE_I,    // write
    input wire logic [7:0]    PADDR_I,     // address
    input wire logic [31:0]   PWDATA_I,    // wdata
    input wire logic [31:0]   PRDATA_O,    // rdata
    input wire logic          PREADY_O,    // ready
    input wire logic          PSLVERR_O,   // error
    input wire logic          COMBO_EN_I,  // combo
    input wire logic [FW-1:0] FREQ_CTRL_O, // steering
    input wire logic          USE_REF_O,   // follow ref
    input wire logic [2:0]    STATE_O,     // state
    input wire logic          ALIGN_O      // align
);
    logic [1:0] mode_q;
    logic [1:0] age_q;
    function automatic logic legal(input logic [2:0] a, input logic [2:0] b);
        return {a, b} inside {6'h01, 6'h08, 6'h0A, 6'h13, 6'h14, 6'h1C, 6'h23, 6'h22};
    endfunction : legal
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // mode shadow; age hides the few cycles the state needs to follow a write
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mode_q <= 2'h0;
            age_q  <= 2'h0;
        end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
                     && PADDR_I == dpsfa_pkg::OFS_CTRL && PWDATA_I[1:0] != mode_q) begin
            mode_q <= PWDATA_I[1:0];
            age_q  <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    ready_follows_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("ready missing after access phase");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    err_no_data_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000)
        else $error("error response malformed");
    reset_freerun_a: assert property ($rose(RST_N_I) |-> STATE_O == 3'h0 && !ALIGN_O)
        else $error("not free-run after reset");
    auto_moves_a: assert property (
        mode_q == 2'h0 && age_q == 2'h3 && $changed(STATE_O) |-> legal($past(STATE_O), STATE_O))
        else $error("illegal automatic state change");
    forced_state_a: assert property (mode_q != 2'h0 && age_q == 2'h3 |->
        STATE_O == (mode_q == 2'h1 ? 3'h2 : (mode_q == 2'h2 ? 3'h0 : 3'h3)))
        else $error("forced mode ignored");
    freerun_quiet_a: assert property (STATE_O == 3'h0 && $past(STATE_O) == 3'h0
        && !$past(COMBO_EN_I) && !$past(COMBO_EN_I, 2) |-> FREQ_CTRL_O == {FW{1'b0}} && !USE_REF_O)
        else $error("free-run output influenced");
    holdover_keep_a: assert property (STATE_O == 3'h3 && $past(STATE_O) == 3'h3
        && $past(STATE_O, 2) == 3'h3 |-> $stable(FREQ_CTRL_O) && !USE_REF_O)
        else $error("holdover word moved");
    align_single_a: assert property (ALIGN_O |=> !ALIGN_O)
        else $error("align strobe too long");
endmodule : dpsfa_asserts
bind dpsfa_channel dpsfa_asserts #(.FW(FW)) dpsfa_asserts_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .COMBO_EN_I(COMBO_EN_I),
    .FREQ_CTRL_O(FREQ_CTRL_O), .USE_REF_O(USE_REF_O), .STATE_O(STATE_O), .ALIGN_O(ALIGN_O)
);
`default_nettype wire

// ### sim/dpsfa_ref_src.sv
`timescale 1ns/10ps
`default_nettype none
module dpsfa_ref_src (
    input  wire logic       fire_i, // start one frame pulse
    input  wire logic       inv_i,  // frame line idles high
    output logic      [3:0] pins_o  // reference pins
);
    logic ref_q = 1'b0;
    logic frm_q = 1'b0;
    always #100 ref_q = ~ref_q;
    // frame starts on a falling ref edge, keeping the integer relation
    always @(posedge fire_i) begin
        @(negedge ref_q);
        frm_q = 1'b1;
        repeat (2) @(negedge ref_q);
        frm_q = 1'b0;
    end
    // spare pins pulled low
    assign pins_o = {2'b00, ref_q, frm_q ^ inv_i};
endmodule : dpsfa_ref_src
`default_nettype wire

// ### sim/dpll_state_and_frame_align_test.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_state_and_frame_align_test;
    logic        clk, rst_n, psel, pen, pwr, fire, inv, cen, hi, prdy, perr, er, use_ref, align;
    logic [7:0]  padr;
    logic [31:0] pwd, prd, rd;
    logic [3:0]  pins, qual, refsel, ofrm, oclk;
    logic [15:0] rnd, phe, lf, cf, fq;
    logic [2:0]  st;
    int          n_errors, samples_checked;
    dpsfa_channel dpsfa_channel_inst (
        .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .REF_PIN_I(pins), .REF_QUAL_I(qual), .REF_PRIO_HI_I(4'h0), .PHASE_ERR_I(phe),
        .LOOP_FREQ_I(lf), .COMBO_FREQ_I(cf), .COMBO_EN_I(cen), .FREQ_CTRL_O(fq),
        .USE_REF_O(use_ref), .STATE_O(st), .REF_SEL_O(refsel), .ALIGN_O(align),
        .OUT_CLK_O(oclk), .OUT_FRAME_O(ofrm)
    );
    dpsfa_ref_src dpsfa_ref_src_inst (.fire_i(fire), .inv_i(inv), .pins_o(pins));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [2:0] fst(input int m);
        return m == 1 ? 3'h2 : (m == 2 ? 3'h0 : 3'h3);
    endfunction : fst
    function automatic logic [31:0] rst_val(input int k);
        case (k)
            0: return dpsfa_pkg::CTRL_RST;
            1: return dpsfa_pkg::LOCKCFG_RST;
            2: return dpsfa_pkg::OUTDIV_RST;
            4: return dpsfa_pkg::SEL_RST;
            default: return 32'h0000_0000;
        endcase
    endfunction : rst_val
    function automatic logic in_win(input int c, input logic sy);
        return sy ? (c >= 2 && c <= 9) : (c >= 11 && c <= 20);
    endfunction : in_win
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic ws(input logic [2:0] s);
        int n;
        n = 0;
        while (st !== s && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({29'h0, st}, {29'h0, s});
    endtask : ws
    task automatic frame(input int i);
        int   c;
        int   w;
        logic sy;
        sy = i >= 8;
        apb(1'b1, dpsfa_pkg::OFS_CTRL, {19'h0, 1'b1, i[3:0], i[2:0], i[0], sy, !sy, 2'h0});
        inv <= i[0];
        repeat (30) @(posedge clk);
        fire <= 1'b1;
        c = 0;
        while (pins[0] === i[0] && c < 100) begin
            @(posedge clk);
            c++;
        end
        c = 0;
        while (align !== 1'b1 && c < 60) begin
            @(posedge clk);
            c++;
        end
        chk({31'h0, in_win(c, sy)}, 32'h1);
        c = 0;
        while (ofrm[0] !== 1'b1 && c < 20) begin
            @(posedge clk);
            c++;
        end
        w = 0;
        while (ofrm[0] === 1'b1 && w < 64) begin
            @(posedge clk);
            w++;
        end
        chk(w, (i % 8 + 1) * 4);
        fire <= 1'b0;
        repeat (60) @(posedge clk);
    endtask : frame
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // random loop word every cycle; phase error just over or under threshold
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        lf  <= rnd;
        phe <= hi ? {9'h000, rnd[6:0]} + 16'h0011 : {12'h000, rnd[3:0]};
    end
    initial begin
        #200_000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {n_errors, samples_checked} = 64'h0;
        {rst_n, psel, pen, pwr, fire, inv, cen, hi} = 8'h01;
        {padr, pwd, qual, rnd, lf, phe, cf} = {48'h0, 16'hDE71, 48'h0};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ws(3'h0);
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, rst_val(k));
            chk({31'h0, er}, {31'h0, k == 5});
        end
        apb(1'b1, dpsfa_pkg::OFS_SEL, 32'h0000_0110);
        apb(1'b0, dpsfa_pkg::OFS_SEL, 32'h0);
        chk(rd, 32'h0000_0110);
        for (int i = 0; i < 10; i++) frame(i);
        cf  <= rnd;
        cen <= 1'b1;
        repeat (4) @(posedge clk);
        chk({16'h0, fq}, {16'h0, cf});
        cen  <= 1'b0;
        qual <= 4'h1;
        ws(3'h1);
        qual <= 4'h0;
        ws(3'h0);
        qual <= 4'h1;
        ws(3'h1);
        qual <= 4'h2;
        repeat (20) @(posedge clk);
        chk({29'h0, st}, 32'h1);
        hi <= 1'b0;
        ws(3'h2);
        chk({28'h0, refsel}, 32'h2);
        qual <= 4'h1;
        ws(3'h4);
        ws(3'h2);
        qual <= 4'h0;
        ws(3'h3);
        hi   <= 1'b1;
        qual <= 4'h4;
        ws(3'h4);
        qual <= 4'h0;
        ws(3'h3);
        qual <= 4'h1;
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, dpsfa_pkg::OFS_CTRL, 32'(m));
            ws(fst(m));
        end
        repeat (30) @(posedge clk);
        chk({29'h0, st}, 32'h3);
        tally_and_finish();
    end
endmodule : dpll_state_and_frame_align_test
`default_nettype wire
